// >>> fmam_map.svh
// Functional notes
// - Memory holds 176 columns by 220 rows, 18 bits.
// - Scan and host may hit one word together.
// - Row mirror reverses gate line to row order.
// - Column mirror puts column 175 at left.
// - Subpixel flag swaps red and blue outputs.
// - Mode 00 shows columns 0-175, rows 0-219.
// - Mode 01 shows columns 0-175, rows 0-175.
// - Mode 11 shows columns 0-175, rows 0-131.
// - Word at column 0, row 0 shows top-left.
// - Scroll set by area heights and start address.
// - Scan order flag swaps top and bottom areas.
// - Two words build a pixel, then one write.
// - Window addresses stay inside valid column/row range.
// - Exchange set: row steps, wraps, then column steps.
// - Exchange clear: column steps, wraps, then row steps.
// - After window end both pointers reload start.
// - Memory command reloads column and row start.
// - Each pixel access steps column or row, per exchange bit.
// - Control byte: bit5 exchange, bit6/7 mirrors.
`ifndef FMAM_MAP_SVH
`define FMAM_MAP_SVH

`define FMAM_OFF_ACCESS_CTRL   8'h00
`define FMAM_OFF_DISPLAY_MODE  8'h04
`define FMAM_OFF_COLUMN_RANGE  8'h08
`define FMAM_OFF_ROW_RANGE     8'h0C
`define FMAM_OFF_SCROLL_DEF    8'h10
`define FMAM_OFF_SCROLL_START  8'h14
`define FMAM_OFF_PARTIAL_LINES 8'h18
`define FMAM_OFF_COMMAND       8'h1C
`define FMAM_OFF_PIXEL_DATA    8'h20
`define FMAM_OFF_STATUS        8'h24

`define FMAM_IDX_ACCESS_CTRL   4'h0
`define FMAM_IDX_DISPLAY_MODE  4'h1
`define FMAM_IDX_COLUMN_RANGE  4'h2
`define FMAM_IDX_ROW_RANGE     4'h3
`define FMAM_IDX_SCROLL_DEF    4'h4
`define FMAM_IDX_SCROLL_START  4'h5
`define FMAM_IDX_PARTIAL_LINES 4'h6
`define FMAM_IDX_COMMAND       4'h7
`define FMAM_IDX_PIXEL_DATA    4'h8
`define FMAM_IDX_STATUS        4'h9

`define FMAM_BIT_ROW_MIRROR    7
`define FMAM_BIT_COL_MIRROR    6
`define FMAM_BIT_EXCHANGE      5
`define FMAM_BIT_SCAN_ORDER    4
`define FMAM_BIT_SUBPIXEL_SWAP 3

`define FMAM_CMD_NONE          8'h00
`define FMAM_CMD_MEM_WRITE     8'h01
`define FMAM_CMD_MEM_READ      8'h02

`define FMAM_RES_220           2'h0
`define FMAM_RES_176           2'h1
`define FMAM_RES_132           2'h3
`define FMAM_LINES_220         9'h0DC
`define FMAM_LINES_176         9'h0B0
`define FMAM_LINES_132         9'h084

`define FMAM_COLUMNS           16'h00B0
`define FMAM_LAST_COLUMN       8'hAF
`define FMAM_LAST_ROW          8'hDB
`define FMAM_MEM_WORDS         38720
`define FMAM_RESET_TFA         8'h00
`define FMAM_RESET_VSA         8'hDC
`define FMAM_RESET_BFA         8'h00
`define FMAM_RESP_OKAY         2'h0
`define FMAM_RESP_SLVERR       2'h2

`endif

// >>> fmam_pkg.sv
package fmam_pkg;

    typedef enum logic [1:0] {
        MODE_IDLE  = 2'b00,
        MODE_WRITE = 2'b01,
        MODE_READ  = 2'b10
    } access_mode_t;

endpackage

// >>> frame_memory_address_mapper.sv
`timescale 1ns/1ps
`default_nettype none
`include "fmam_map.svh"

module frame_memory_address_mapper
    import fmam_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic [7:0]             gateLine,
    output logic [7:0]             sourcePixel,
    output logic [17:0]            sourceData,
    output logic                   sourceDisplay
);

    // Register state.
    logic [7:0]      accessCtrl;
    logic [1:0]      panelResolutionSelect;
    logic            partialOn;
    logic            scrollOn;
    logic [7:0]      windowStartColumn;
    logic [7:0]      windowEndColumn;
    logic [7:0]      windowStartRow;
    logic [7:0]      windowEndRow;
    logic [7:0]      topFixedAreaHeight;
    logic [7:0]      scrollAreaHeight;
    logic [7:0]      bottomFixedAreaHeight;
    logic [7:0]      scrollStartAddress;
    logic [7:0]      partialStartLine;
    logic [7:0]      partialEndLine;
    access_mode_t    accessMode;
    logic            wordPhase;
    logic [8:0]      upperWord;
    logic [7:0]      columnCounter;
    logic [7:0]      rowCounter;
    logic [17:0]     hostReadPixel;

    // Bus handshake state.
    logic              awHave;
    logic              wHave;
    logic [ADDR_W-1:0] awAddrHeld;
    logic [31:0]       wDataHeld;
    logic [3:0]        wStrbHeld;

    // Scan state.
    logic [7:0]  scanColumn;
    logic [8:0]  scanLine;
    logic [17:0] scanWord;
    logic [7:0]  scanLineDly;
    logic [7:0]  scanColumnDly;
    logic        scanShowDly;

    logic [17:0] frameMemory [0:`FMAM_MEM_WORDS-1];

    function automatic logic regHit(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'b00) && ({2'b00, a[ADDR_W-1:2]} <= {4'h0, `FMAM_IDX_STATUS});
    endfunction

    function automatic logic [3:0] regIndex(input logic [ADDR_W-1:0] a);
        return a[5:2];
    endfunction

    function automatic logic [15:0] wordAddr(input logic [7:0] col, input logic [7:0] row);
        return 16'({8'h00, row} * `FMAM_COLUMNS + {8'h00, col});
    endfunction

    function automatic logic [7:0] clampColumn(input logic [7:0] v);
        return (v > `FMAM_LAST_COLUMN) ? `FMAM_LAST_COLUMN : v;
    endfunction

    function automatic logic [7:0] clampRow(input logic [7:0] v);
        return (v > `FMAM_LAST_ROW) ? `FMAM_LAST_ROW : v;
    endfunction

    // AXI4-Lite handshakes: one write and one read in flight.
    wire awTaken      = awvalid && awready;
    wire wTaken       = wvalid && wready;
    wire arTaken      = arvalid && arready;
    wire doWrite      = awHave && wHave && !bvalid;
    wire next_awHave  = awTaken || (awHave && !doWrite);
    wire next_wHave   = wTaken || (wHave && !doWrite);
    wire next_bvalid  = doWrite || (bvalid && !bready);
    wire next_rvalid  = arTaken || (rvalid && !rready);
    wire next_awready = !next_awHave && !next_bvalid;
    wire next_wready  = !next_wHave && !next_bvalid;
    wire next_arready = !next_rvalid;

    wire       wrHit  = regHit(awAddrHeld);
    wire [3:0] wrIdx  = regIndex(awAddrHeld);
    wire       rdHit  = regHit(araddr);
    wire [3:0] rdIdx  = regIndex(araddr);
    wire       wrLow  = doWrite && wrHit && wStrbHeld[0];
    wire       wrHigh = doWrite && wrHit && wStrbHeld[2];

    wire [7:0] cmdCode   = wDataHeld[7:0];
    wire       cmdStart  = wrLow && (wrIdx == `FMAM_IDX_COMMAND)
                           && ((cmdCode == `FMAM_CMD_MEM_WRITE) || (cmdCode == `FMAM_CMD_MEM_READ));
    wire       cmdStop   = wrLow && (wrIdx == `FMAM_IDX_COMMAND) && !cmdStart;
    wire       wordIn    = doWrite && wrHit && (wrIdx == `FMAM_IDX_PIXEL_DATA)
                           && (accessMode == MODE_WRITE);
    wire       pixWrite  = wordIn && wordPhase;
    wire       pixRead   = arTaken && rdHit && (rdIdx == `FMAM_IDX_PIXEL_DATA)
                           && (accessMode == MODE_READ);
    wire       pixStep   = pixWrite || pixRead;

    // Address counter stepping.
    wire exchange     = accessCtrl[`FMAM_BIT_EXCHANGE];
    wire colAtEnd     = (columnCounter == windowEndColumn);
    wire rowAtEnd     = (rowCounter == windowEndRow);
    wire [7:0] colInc = 8'(columnCounter + 8'h01);
    wire [7:0] rowInc = 8'(rowCounter + 8'h01);
    wire [7:0] stepColumn = exchange ? (rowAtEnd ? (colAtEnd ? windowStartColumn : colInc)
                                                 : columnCounter)
                                     : (colAtEnd ? windowStartColumn : colInc);
    wire [7:0] stepRow    = exchange ? (rowAtEnd ? windowStartRow : rowInc)
                                     : (colAtEnd ? (rowAtEnd ? windowStartRow : rowInc)
                                                 : rowCounter);
    wire [7:0] next_columnCounter = cmdStart ? windowStartColumn
                                  : (pixStep ? stepColumn : columnCounter);
    wire [7:0] next_rowCounter    = cmdStart ? windowStartRow
                                  : (pixStep ? stepRow : rowCounter);

    wire [15:0] hostAddr = wordAddr(columnCounter, rowCounter);

    // Read data selection.
    wire [31:0] rdMux =
        (rdIdx == `FMAM_IDX_ACCESS_CTRL)   ? {24'h000000, accessCtrl} :
        (rdIdx == `FMAM_IDX_DISPLAY_MODE)  ? {28'h0000000, scrollOn, partialOn, panelResolutionSelect} :
        (rdIdx == `FMAM_IDX_COLUMN_RANGE)  ? {8'h00, windowEndColumn, 8'h00, windowStartColumn} :
        (rdIdx == `FMAM_IDX_ROW_RANGE)     ? {8'h00, windowEndRow, 8'h00, windowStartRow} :
        (rdIdx == `FMAM_IDX_SCROLL_DEF)    ? {8'h00, bottomFixedAreaHeight, scrollAreaHeight,
                                              topFixedAreaHeight} :
        (rdIdx == `FMAM_IDX_SCROLL_START)  ? {24'h000000, scrollStartAddress} :
        (rdIdx == `FMAM_IDX_PARTIAL_LINES) ? {8'h00, partialEndLine, 8'h00, partialStartLine} :
        (rdIdx == `FMAM_IDX_COMMAND)       ? {30'h00000000, accessMode} :
        (rdIdx == `FMAM_IDX_PIXEL_DATA)    ? {14'h0000, hostReadPixel} :
        (rdIdx == `FMAM_IDX_STATUS)        ? {13'h0000, wordPhase, accessMode, rowCounter,
                                              columnCounter} :
                                             32'h00000000;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            awready    <= 1'b0;
            wready     <= 1'b0;
            arready    <= 1'b0;
            bvalid     <= 1'b0;
            rvalid     <= 1'b0;
            bresp      <= `FMAM_RESP_OKAY;
            rresp      <= `FMAM_RESP_OKAY;
            rdata      <= 32'h00000000;
            awHave     <= 1'b0;
            wHave      <= 1'b0;
            awAddrHeld <= '0;
            wDataHeld  <= 32'h00000000;
            wStrbHeld  <= 4'h0;
        end
        else
        begin
            awready <= next_awready;
            wready  <= next_wready;
            arready <= next_arready;
            bvalid  <= next_bvalid;
            rvalid  <= next_rvalid;
            awHave  <= next_awHave;
            wHave   <= next_wHave;
            if (awTaken)
                awAddrHeld <= awaddr;
            if (wTaken)
            begin
                wDataHeld <= wdata;
                wStrbHeld <= wstrb;
            end
            if (doWrite)
                bresp <= wrHit ? `FMAM_RESP_OKAY : `FMAM_RESP_SLVERR;
            if (arTaken)
            begin
                rdata <= rdHit ? rdMux : 32'h00000000;
                rresp <= rdHit ? `FMAM_RESP_OKAY : `FMAM_RESP_SLVERR;
            end
        end
    end

    // Configuration registers, written by byte lane.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            accessCtrl            <= 8'h00;
            panelResolutionSelect <= `FMAM_RES_220;
            partialOn             <= 1'b0;
            scrollOn              <= 1'b0;
            windowStartColumn     <= 8'h00;
            windowEndColumn       <= `FMAM_LAST_COLUMN;
            windowStartRow        <= 8'h00;
            windowEndRow          <= `FMAM_LAST_ROW;
            topFixedAreaHeight    <= `FMAM_RESET_TFA;
            scrollAreaHeight      <= `FMAM_RESET_VSA;
            bottomFixedAreaHeight <= `FMAM_RESET_BFA;
            scrollStartAddress    <= 8'h00;
            partialStartLine      <= 8'h00;
            partialEndLine        <= `FMAM_LAST_ROW;
        end
        else
        begin
            if (wrLow && (wrIdx == `FMAM_IDX_ACCESS_CTRL))
                accessCtrl <= wDataHeld[7:0];
            if (wrLow && (wrIdx == `FMAM_IDX_DISPLAY_MODE))
            begin
                panelResolutionSelect <= wDataHeld[1:0];
                partialOn             <= wDataHeld[2];
                scrollOn              <= wDataHeld[3];
            end
            if (wrLow && (wrIdx == `FMAM_IDX_COLUMN_RANGE))
                windowStartColumn <= clampColumn(wDataHeld[7:0]);
            if (wrHigh && (wrIdx == `FMAM_IDX_COLUMN_RANGE))
                windowEndColumn <= clampColumn(wDataHeld[23:16]);
            if (wrLow && (wrIdx == `FMAM_IDX_ROW_RANGE))
                windowStartRow <= clampRow(wDataHeld[7:0]);
            if (wrHigh && (wrIdx == `FMAM_IDX_ROW_RANGE))
                windowEndRow <= clampRow(wDataHeld[23:16]);
            if (wrLow && (wrIdx == `FMAM_IDX_SCROLL_DEF))
                topFixedAreaHeight <= wDataHeld[7:0];
            if (doWrite && wrHit && wStrbHeld[1] && (wrIdx == `FMAM_IDX_SCROLL_DEF))
                scrollAreaHeight <= wDataHeld[15:8];
            if (wrHigh && (wrIdx == `FMAM_IDX_SCROLL_DEF))
                bottomFixedAreaHeight <= wDataHeld[23:16];
            if (wrLow && (wrIdx == `FMAM_IDX_SCROLL_START))
                scrollStartAddress <= wDataHeld[7:0];
            if (wrLow && (wrIdx == `FMAM_IDX_PARTIAL_LINES))
                partialStartLine <= wDataHeld[7:0];
            if (wrHigh && (wrIdx == `FMAM_IDX_PARTIAL_LINES))
                partialEndLine <= wDataHeld[23:16];
        end
    end

    // Memory access mode, word assembly and address counter.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            accessMode    <= MODE_IDLE;
            wordPhase     <= 1'b0;
            upperWord     <= 9'h000;
            columnCounter <= 8'h00;
            rowCounter    <= 8'h00;
        end
        else
        begin
            if (cmdStart)
                accessMode <= (cmdCode == `FMAM_CMD_MEM_WRITE) ? MODE_WRITE : MODE_READ;
            else if (cmdStop)
                accessMode <= MODE_IDLE;
            if (cmdStart || cmdStop)
                wordPhase <= 1'b0;
            else if (wordIn)
                wordPhase <= !wordPhase;
            if (wordIn && !wordPhase)
                upperWord <= wDataHeld[8:0];
            columnCounter <= next_columnCounter;
            rowCounter    <= next_rowCounter;
        end
    end

    // Scan timing: a pixel per clock across the active lines.
    wire [8:0] activeLines = (panelResolutionSelect == `FMAM_RES_176) ? `FMAM_LINES_176 :
                             (panelResolutionSelect == `FMAM_RES_132) ? `FMAM_LINES_132 :
                                                                        `FMAM_LINES_220;
    wire       lineEnd   = (scanColumn == `FMAM_LAST_COLUMN);
    wire       frameEnd  = lineEnd && (scanLine >= 9'(activeLines - 9'h001));

    wire [8:0] mirroredLine = accessCtrl[`FMAM_BIT_ROW_MIRROR]
                              ? 9'(activeLines - 9'h001 - scanLine) : scanLine;
    wire [8:0] topArea  = {1'b0, accessCtrl[`FMAM_BIT_SCAN_ORDER]
                                 ? bottomFixedAreaHeight : topFixedAreaHeight};
    wire [8:0] areaEnd  = 9'(topArea + {1'b0, scrollAreaHeight});
    wire       inScroll = scrollOn && (mirroredLine >= topArea) && (mirroredLine < areaEnd);
    wire [9:0] shifted  = 10'({1'b0, mirroredLine} + {2'b00, scrollStartAddress} - {1'b0, topArea});
    wire [9:0] wrapped  = (shifted >= {1'b0, areaEnd})
                          ? 10'(shifted - {2'b00, scrollAreaHeight}) : shifted;
    wire [7:0] fetchRow = inScroll ? wrapped[7:0] : mirroredLine[7:0];
    wire [7:0] fetchCol = accessCtrl[`FMAM_BIT_COL_MIRROR]
                          ? 8'(`FMAM_LAST_COLUMN - scanColumn) : scanColumn;
    wire       lineShown = !partialOn || ((scanLine[7:0] >= partialStartLine)
                           && (scanLine[7:0] <= partialEndLine));
    wire [15:0] scanAddr = wordAddr(fetchCol, fetchRow);

    // Independent read and write ports; a collision returns the old word cleanly.
    always_ff @(posedge clk)
    begin
        if (pixWrite)
            frameMemory[hostAddr] <= {upperWord, wDataHeld[8:0]};
        scanWord      <= frameMemory[scanAddr];
        hostReadPixel <= frameMemory[hostAddr];
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            scanColumn    <= 8'h00;
            scanLine      <= 9'h000;
            scanLineDly   <= 8'h00;
            scanColumnDly <= 8'h00;
            scanShowDly   <= 1'b0;
            gateLine      <= 8'h00;
            sourcePixel   <= 8'h00;
            sourceData    <= 18'h00000;
            sourceDisplay <= 1'b0;
        end
        else
        begin
            scanColumn    <= lineEnd ? 8'h00 : 8'(scanColumn + 8'h01);
            if (frameEnd)
                scanLine <= 9'h000;
            else if (lineEnd)
                scanLine <= 9'(scanLine + 9'h001);
            scanLineDly   <= scanLine[7:0];
            scanColumnDly <= scanColumn;
            scanShowDly   <= lineShown;
            gateLine      <= scanLineDly;
            sourcePixel   <= scanColumnDly;
            sourceDisplay <= scanShowDly;
            if (!scanShowDly)
                sourceData <= 18'h00000;
            else if (accessCtrl[`FMAM_BIT_SUBPIXEL_SWAP])
                sourceData <= {scanWord[5:0], scanWord[11:6], scanWord[17:12]};
            else
                sourceData <= scanWord;
        end
    end

endmodule
`default_nettype wire

// >>> fmam_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fmam_checker #(
    parameter int ADDR_W = 8
)
(
    input wire logic              clk,
    input wire logic              srst,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic              awvalid,
    input wire logic              awready,
    input wire logic [31:0]       wdata,
    input wire logic [3:0]        wstrb,
    input wire logic              wvalid,
    input wire logic              wready,
    input wire logic [1:0]        bresp,
    input wire logic              bvalid,
    input wire logic              bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic              arvalid,
    input wire logic              arready,
    input wire logic [31:0]       rdata,
    input wire logic [1:0]        rresp,
    input wire logic              rvalid,
    input wire logic              rready,
    input wire logic [7:0]        gateLine,
    input wire logic [7:0]        sourcePixel,
    input wire logic [17:0]       sourceData,
    input wire logic              sourceDisplay
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Pixel step, wrap and line-steady checks wait until the scan pipeline has refilled after reset.
    logic [2:0] settle;
    always_ff @(posedge clk)
        settle <= srst ? 3'h0 : (settle == 3'h7 ? settle : settle + 3'h1);
    AST_BRESP_HOLD:
        assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
    AST_RDATA_HOLD:
        assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer dropped");
    AST_WRITE_ANSWER:
        assert property (awvalid && awready && wvalid && wready
                         |=> !awready && !wready ##1 bvalid && !awready && !wready)
        else $error("write answer late");
    AST_READ_ANSWER:
        assert property (arvalid && arready |=> rvalid && !arready) else $error("read answer late");
    AST_RESP_CODE:
        assert property (bvalid |-> bresp == 2'h0 || bresp == 2'h2) else $error("bad bresp");
    AST_PIXEL_STEP:
        assert property (settle == 3'h7 && sourcePixel != 8'hAF |=> sourcePixel == $past(sourcePixel) + 8'h1)
        else $error("scan pixel skipped");
    AST_LINE_WRAP:
        assert property (settle == 3'h7 && sourcePixel == 8'hAF |=> sourcePixel == 8'h0)
        else $error("line not 176 pixels");
    AST_LINE_STEADY:
        assert property (settle == 3'h7 && sourcePixel != 8'hAF |=> $stable(gateLine))
        else $error("gate line moved in line");
    AST_ROW_RANGE:
        assert property (gateLine <= 8'hDB) else $error("gate line past 219");
    AST_BLANK_DATA:
        assert property (!sourceDisplay |-> sourceData == 18'h0) else $error("blank line has data");
endmodule
bind frame_memory_address_mapper fmam_checker #(.ADDR_W(ADDR_W)) mapper_check (
    .clk(clk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .gateLine(gateLine),
    .sourcePixel(sourcePixel), .sourceData(sourceData), .sourceDisplay(sourceDisplay));
`default_nettype wire

// >>> host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input  wire logic        clk,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} <= '0;
    // Released address and data lines show the inverse of their last value; wstrb keeps its value.
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid, bready} <= 3'b111;
        forever
        begin
            @(posedge clk);
            if (awvalid && awready)
                {awvalid, awaddr} <= {1'b0, ~a};
            if (wvalid && wready)
                {wvalid, wdata} <= {1'b0, ~d};
            if (bvalid)
                break;
        end
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        forever
        begin
            @(posedge clk);
            if (arvalid && arready)
                {arvalid, araddr} <= {1'b0, ~a};
            if (rvalid)
                break;
        end
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> test_frame_memory_address_mapper.sv
`timescale 1ns/1ps
`default_nettype none
module test_frame_memory_address_mapper;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  awaddr, araddr, gateLine, sourcePixel, mx;
    logic [31:0] wdata, rdata, rv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic [17:0] sourceData, pv;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, sourceDisplay;
    logic        arvalid, arready, rvalid, rready;
    int          fails = 0;
    int          n_checks = 0;
    int          j;
    always #50 clk = ~clk;
    frame_memory_address_mapper dut (
        .clk(clk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .gateLine(gateLine),
        .sourcePixel(sourcePixel), .sourceData(sourceData), .sourceDisplay(sourceDisplay));
    host_bus_model host (
        .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        host.write_reg(a, d, rs);
        check({30'h0, rs}, {30'h0, er});
    endtask
    task automatic rdck(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        host.read_reg(a, rv, rs);
        check(rv, e);
        check({30'h0, rs}, {30'h0, er});
    endtask
    task automatic scan(input logic [7:0] g, input logic [7:0] p, input logic [18:0] e);
        repeat (4) @(negedge clk);
        for (j = 0; j < 40000 && (gateLine !== g || sourcePixel !== p); j++)
            @(negedge clk);
        check({12'h0, j >= 40000, sourceDisplay, sourceData}, {13'h0, e});
    endtask
    // Status word expected after n pixels in a 3x2 window at column 2, row 5.
    function automatic logic [31:0] at(int m, int n, int md, int ph);
        int c;
        int r;
        c = m ? 2 + n / 2 : 2 + n % 3;
        r = m ? 5 + n % 2 : 5 + n / 3;
        return 32'(ph * 262144 + md * 65536 + r * 256 + c);
    endfunction
    initial
    begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rdck(8'h08, 32'h00AF0000, 2'h0);
        rdck(8'h0C, 32'h00DB0000, 2'h0);
        rdck(8'h10, 32'h0000DC00, 2'h0);
        rdck(8'h40, 32'h0, 2'h2);
        wr(8'h40, 32'h1, 2'h2);
        wr(8'h08, 32'h00FF00B5, 2'h0);
        rdck(8'h08, 32'h00AF00AF, 2'h0);
        wr(8'h08, 32'h00040002, 2'h0);
        wr(8'h0C, 32'h00060005, 2'h0);
        for (int m = 0; m < 2; m++)
        begin
            wr(8'h00, m ? 32'h20 : 32'h0, 2'h0);
            wr(8'h1C, 32'h1, 2'h0);
            rdck(8'h24, at(m, 0, 1, 0), 2'h0);
            for (int k = 0; k < 6; k++)
            begin
                pv = 18'h2A000 + 18'(m * 64 + k);
                wr(8'h20, {23'h0, pv[17:9]}, 2'h0);
                rdck(8'h24, at(m, k, 1, 1), 2'h0);
                wr(8'h20, {23'h0, pv[8:0]}, 2'h0);
                rdck(8'h24, at(m, (k + 1) % 6, 1, 0), 2'h0);
            end
        end
        wr(8'h00, 32'h0, 2'h0);
        wr(8'h1C, 32'h2, 2'h0);
        rdck(8'h24, at(0, 0, 2, 0), 2'h0);
        for (int n = 0; n < 6; n++)
            rdck(8'h20, 32'h2A040 + 32'((n % 3) * 2 + n / 3), 2'h0);
        rdck(8'h24, at(0, 0, 2, 0), 2'h0);
        wr(8'h1C, 32'h0, 2'h0);
        rdck(8'h1C, 32'h0, 2'h0);
        wr(8'h04, 32'h3, 2'h0);
        for (j = 0; j < 40000 && (gateLine !== 8'h0 || sourcePixel !== 8'h0); j++)
            @(negedge clk);
        mx = 8'h0;
        repeat (132 * 176)
        begin
            @(negedge clk);
            if (gateLine > mx)
                mx = gateLine;
        end
        check({24'h0, mx}, 32'h83);
        check({16'h0, gateLine, sourcePixel}, 32'h0);
        wr(8'h10, 32'h0002D703, 2'h0);
        wr(8'h14, 32'h00000004, 2'h0);
        wr(8'h00, 32'h10, 2'h0);
        wr(8'h04, 32'hB, 2'h0);
        scan(8'h03, 8'h02, 19'h6A040);
        wr(8'h00, 32'h0, 2'h0);
        scan(8'h04, 8'h02, 19'h6A040);
        wr(8'h04, 32'h3, 2'h0);
        scan(8'h05, 8'h02, 19'h6A040);
        wr(8'h04, 32'h7, 2'h0);
        wr(8'h18, 32'h00810007, 2'h0);
        scan(8'h06, 8'h02, 19'h0);
        wr(8'h00, 32'hC8, 2'h0);
        scan(8'h7D, 8'hAD, 19'h4106A);
        end_of_test();
    end
    initial
    begin
        #9000000;
        fails++;
        end_of_test();
    end
endmodule
`default_nettype wire
